// ---- src/bbse_exec.sv ----
// Execute stage for the four clear-flag branches, the relative branch and
// the single-bit set. Assumes the fetch stage presents the instruction word
// and the incremented counter throughout phase one, flags stay valid through
// phase three, and data memory answers a read in the same phase.
`default_nettype none
`timescale 1ns/1ns

// Function
// - Carry clear opcode branches when carry zero
// - Negative clear opcode branches when negative zero
// - Overflow clear opcode branches, else falls through
// - Zero clear opcode branches, else falls through
// - Target is incremented counter plus twice offset
// - Relative base is the following instruction
// - Conditional: one cycle, two when taken
// - Relative branch always taken, two cycles
// - Bit set forces one bit, keeps others
// - Select zero access bank, one bank register
// - Extended set indexes offsets up to 5Fh
module bbse_exec #(
  parameter int PC_W = bbse_pkg::PC_WIDTH
) (
  input  wire logic                               clk_in,
  input  wire logic                               arst_n_in,
  input  wire logic [bbse_pkg::INSTR_WIDTH-1:0]   instr_in,
  input  wire logic [PC_W-1:0]                    pc_next_in,
  input  wire logic                               carry_flag_in,
  input  wire logic                               negative_flag_in,
  input  wire logic                               overflow_flag_in,
  input  wire logic                               zero_flag_in,
  input  wire logic [bbse_pkg::BANK_WIDTH-1:0]    bank_select_reg_in,
  input  wire logic                               ext_set_enable_in,
  input  wire logic [bbse_pkg::DADDR_WIDTH-1:0]   index_base_in,
  input  wire logic [7:0]                         mem_rdata_in,
  output var  bbse_pkg::bbse_phase_t              phase_out,
  output logic                                    pc_load_out,
  output logic      [PC_W-1:0]                    pc_target_out,
  output logic                                    prefetch_flush_out,
  output logic      [bbse_pkg::DADDR_WIDTH-1:0]   mem_addr_out,
  output logic                                    mem_rd_out,
  output logic                                    mem_wr_out,
  output logic      [7:0]                         mem_wdata_out
);
  import bbse_pkg::*;

  // Refuse a counter too narrow for the doubled relative offset
  if (PC_W < OFS_WIDTH + 1) begin : g_pc_w_chk
    $error("PC_W too narrow for the relative offset");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  bbse_phase_t             phase_w;         // Current phase
  logic [PC_W-1:0]         target_w;        // Computed branch target
  logic [OFS_WIDTH-1:0]    ofs_w;           // Offset of the held word
  logic [DADDR_WIDTH-1:0]  addr_w;          // Resolved file address
  logic                    cond_w;          // Branch condition this cycle

  bbse_state_t             state_reg;       // Executing or flushing
  bbse_state_t             state_next;
  bbse_op_t                op_reg;          // Decoded operation
  bbse_op_t                op_next;
  logic [INSTR_WIDTH-1:0]  instr_reg;       // Held instruction word
  logic [INSTR_WIDTH-1:0]  instr_next;
  logic [PC_W-1:0]         base_reg;        // Incremented counter, held
  logic [PC_W-1:0]         base_next;
  logic [DADDR_WIDTH-1:0]  addr_reg;        // File address for the cycle
  logic [DADDR_WIDTH-1:0]  addr_next;
  logic [7:0]              data_reg;        // Read data, then write data
  logic [7:0]              data_next;
  logic [PC_W-1:0]         target_reg;      // Counter load value
  logic [PC_W-1:0]         target_next;
  logic                    pc_load_reg;     // Counter load strobe
  logic                    pc_load_next;
  logic                    rd_reg;          // Memory read strobe
  logic                    rd_next;
  logic                    wr_reg;          // Memory write strobe
  logic                    wr_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  bbse_phase_gen u_phase (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .phase_out (phase_w)
  );

  assign ofs_w = ofs_field(instr_reg, op_reg);

  bbse_target_calc #(
    .PC_W (PC_W)
  ) u_target (
    .pc_next_in (base_reg),
    .offset_in  (ofs_w),
    .target_out (target_w)
  );

  // Condition of the held branch; a clear flag or the relative branch takes it
  always_comb begin
    unique case (op_reg)
      OP_CARRY_CLR: cond_w = !carry_flag_in;
      OP_NEG_CLR:   cond_w = !negative_flag_in;
      OP_OVF_CLR:   cond_w = !overflow_flag_in;
      OP_ZERO_CLR:  cond_w = !zero_flag_in;
      OP_ALWAYS:    cond_w = 1'b1;
      default:      cond_w = 1'b0;               // Not a branch
    endcase
  end

  // File address from the incoming word; bank is caught at decode time
  always_comb begin
    if (!instr_in[ACC_SEL_BIT] && ext_set_enable_in && instr_in[7:0] <= LIT_OFS_MAX) begin
      addr_w = index_base_in + {4'h0, instr_in[7:0]};
    end else if (instr_in[ACC_SEL_BIT]) begin
      addr_w = {bank_select_reg_in, instr_in[7:0]};
    end else if (instr_in[7:0] < ACCESS_SPLIT) begin
      addr_w = {ACCESS_LO_BANK, instr_in[7:0]};
    end else begin
      addr_w = {ACCESS_HI_BANK, instr_in[7:0]};                  // SFR half
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle sequencing, one step per phase
  always_comb begin
    state_next   = state_reg;
    op_next      = op_reg;
    instr_next   = instr_reg;
    base_next    = base_reg;
    addr_next    = addr_reg;
    data_next    = data_reg;
    target_next  = target_reg;
    pc_load_next = 1'b0;
    rd_next      = 1'b0;
    wr_next      = 1'b0;
    unique case (phase_w)
      PH_Q1: begin
        // Decode; a flushed cycle discards its prefetched word
        if (state_reg == ST_FLUSH) begin
          op_next = OP_NONE;
        end else begin
          op_next    = op_decode(instr_in);
          instr_next = instr_in;
          base_next  = pc_next_in;
          addr_next  = addr_w;
          rd_next    = (op_decode(instr_in) == OP_BIT_SET);
        end
      end
      PH_Q2: begin
        // Read register or literal
        data_next = mem_rdata_in;
      end
      PH_Q3: begin
        // Process: pick target or merge the bit
        target_next  = target_w;
        pc_load_next = cond_w;
        if (op_reg == OP_BIT_SET) begin
          data_next = data_reg | bit_mask(instr_reg);
          wr_next   = 1'b1;
        end
      end
      PH_Q4: begin
        // Taken branch costs one idle cycle after this one
        state_next = pc_load_reg ? ST_FLUSH : ST_EXEC;
        op_next    = OP_NONE;
      end
    endcase
  end

  // Register only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg   <= ST_EXEC;
      op_reg      <= OP_NONE;
      instr_reg   <= 16'h0000;
      base_reg    <= '0;
      addr_reg    <= 12'h000;
      data_reg    <= 8'h00;
      target_reg  <= '0;
      pc_load_reg <= 1'b0;
      rd_reg      <= 1'b0;
      wr_reg      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      instr_reg   <= instr_next;
      base_reg    <= base_next;
      addr_reg    <= addr_next;
      data_reg    <= data_next;
      target_reg  <= target_next;
      pc_load_reg <= pc_load_next;
      rd_reg      <= rd_next;
      wr_reg      <= wr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; no status flag output exists, so flags cannot change here
  assign phase_out          = phase_w;
  assign pc_load_out        = pc_load_reg;
  assign pc_target_out      = target_reg;
  assign prefetch_flush_out = (state_reg == ST_FLUSH);
  assign mem_addr_out       = addr_reg;
  assign mem_rd_out         = rd_reg;
  assign mem_wr_out         = wr_reg;
  assign mem_wdata_out      = data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence flush_cycle_s;
    prefetch_flush_out[*4];
  endsequence

  sequence back_to_exec_s;
    !prefetch_flush_out && phase_out == PH_Q1;
  endsequence

  carry_branch_a: assert property (
    op_reg == OP_CARRY_CLR && phase_out == PH_Q4 |-> pc_load_out == !$past(carry_flag_in))
    else $error("carry clear branch decision wrong");

  neg_branch_a: assert property (
    op_reg == OP_NEG_CLR && phase_out == PH_Q4 |-> pc_load_out == !$past(negative_flag_in))
    else $error("negative clear branch decision wrong");

  ovf_branch_a: assert property (
    op_reg == OP_OVF_CLR && phase_out == PH_Q4 |-> pc_load_out == !$past(overflow_flag_in))
    else $error("overflow clear branch decision wrong");

  zero_branch_a: assert property (
    op_reg == OP_ZERO_CLR && phase_out == PH_Q4 |-> pc_load_out == !$past(zero_flag_in))
    else $error("zero clear branch decision wrong");

  target_value_a: assert property (
    pc_load_out |-> pc_target_out ==
      base_reg + PC_W'({{(PC_W-OFS_WIDTH){ofs_w[OFS_WIDTH-1]}}, ofs_w} << 1))
    else $error("branch target mismatch");

  target_base_a: assert property (
    phase_out == PH_Q1 && !prefetch_flush_out |=> base_reg == $past(pc_next_in))
    else $error("relative base not the incremented counter");

  taken_flush_a: assert property (
    pc_load_out |=> flush_cycle_s ##1 back_to_exec_s)
    else $error("taken branch did not take exactly two cycles");

  skip_one_a: assert property (
    phase_out == PH_Q4 && !pc_load_out |=> !prefetch_flush_out)
    else $error("untaken branch stalled");

  always_taken_a: assert property (
    op_reg == OP_ALWAYS && phase_out == PH_Q4 |-> pc_load_out)
    else $error("relative branch not taken");

  bit_merge_a: assert property (
    mem_wr_out |-> mem_wdata_out == ($past(mem_rdata_in, 2) | bit_mask(instr_reg)))
    else $error("bit set data wrong");

  bank_addr_a: assert property (
    mem_rd_out && instr_reg[ACC_SEL_BIT] |-> mem_addr_out == {$past(bank_select_reg_in),
      instr_reg[7:0]})
    else $error("bank addressed wrongly");

  indexed_addr_a: assert property (
    mem_rd_out && !instr_reg[ACC_SEL_BIT] && $past(ext_set_enable_in) &&
      instr_reg[7:0] <= LIT_OFS_MAX |-> mem_addr_out == $past(index_base_in) + {4'h0, instr_reg[7:0]})
    else $error("indexed literal offset address wrong");

  flush_idle_a: assert property (
    prefetch_flush_out |-> !mem_rd_out && !mem_wr_out && !pc_load_out)
    else $error("activity during flush cycle");

  rd_wr_order_a: assert property (
    mem_rd_out |-> phase_out == PH_Q2 ##2 (mem_wr_out && phase_out == PH_Q4 && $stable(mem_addr_out)))
    else $error("bit set read/write phases wrong");

  // Strobes stay in their phases and belong only to their own opcodes
  load_in_q4_a: assert property (
    pc_load_out |-> phase_out == PH_Q4)
    else $error("counter load outside the fourth phase");

  load_only_branch_a: assert property (
    pc_load_out |-> op_reg inside {OP_CARRY_CLR, OP_NEG_CLR, OP_OVF_CLR, OP_ZERO_CLR, OP_ALWAYS})
    else $error("counter loaded by a word that is not a branch");

  bit_read_only_a: assert property (
    phase_out == PH_Q2 && op_reg != OP_BIT_SET |-> !mem_rd_out)
    else $error("register read for a word that is not a bit set");

  write_after_read_a: assert property (
    mem_wr_out |-> $past(mem_rd_out, 2) && $past(phase_out, 2) == PH_Q2)
    else $error("bit set write without its read");

  // Plain access bank: low half in bank zero, upper half in the top bank
  access_addr_a: assert property (
    mem_rd_out && !instr_reg[ACC_SEL_BIT] && !$past(ext_set_enable_in) |->
      mem_addr_out == {(instr_reg[7:0] < ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK, instr_reg[7:0]})
    else $error("access bank addressed wrongly");
endmodule

`default_nettype wire

// ---- src/bbse_pkg.sv ----
// Constants, types and decode helpers for the branch and bit-set executor.
// Assumes one core clock tick per instruction phase, four phases per cycle.
`default_nettype none

package bbse_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PC_WIDTH    = 21;  // Byte address of program memory
  localparam int DADDR_WIDTH = 12;  // Data memory address
  localparam int BANK_WIDTH  = 4;   // Bank select register width
  localparam int INSTR_WIDTH = 16;  // One instruction word
  localparam int OFS_WIDTH   = 11;  // Widest relative offset field

  ////////////////////////////////////////////////////////////////////////////
  // Opcode patterns and field positions
  localparam logic [7:0] OPC_CARRY_CLR = 8'hE3;  // Upper byte, carry clear
  localparam logic [7:0] OPC_NEG_CLR   = 8'hE7;  // Upper byte, negative clear
  localparam logic [7:0] OPC_OVF_CLR   = 8'hE5;  // Upper byte, overflow clear
  localparam logic [7:0] OPC_ZERO_CLR  = 8'hE1;  // Upper byte, zero clear
  localparam logic [4:0] OPC_ALWAYS    = 5'h1A;  // Top five bits, relative
  localparam logic [3:0] OPC_BIT_SET   = 4'h8;   // Top nibble, bit set
  localparam int ACC_SEL_BIT = 8;                // Access-select bit
  localparam int BIT_IDX_LSB = 9;                // Bit index, three bits
  localparam logic [7:0] LIT_OFS_MAX  = 8'h5F;   // Highest indexed offset
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;   // Access bank low/high split
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;  // Bank of upper access half
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;  // Bank of lower access half

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbse_phase_t;
  typedef enum logic [2:0] {OP_NONE, OP_CARRY_CLR, OP_NEG_CLR, OP_OVF_CLR,
                            OP_ZERO_CLR, OP_ALWAYS, OP_BIT_SET} bbse_op_t;
  typedef enum logic {ST_EXEC, ST_FLUSH} bbse_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Classify one instruction word
  function automatic bbse_op_t op_decode(input logic [INSTR_WIDTH-1:0] w);
    bbse_op_t r;
    r = OP_NONE;
    if (w[15:8] == OPC_CARRY_CLR) r = OP_CARRY_CLR;
    else if (w[15:8] == OPC_NEG_CLR) r = OP_NEG_CLR;
    else if (w[15:8] == OPC_OVF_CLR) r = OP_OVF_CLR;
    else if (w[15:8] == OPC_ZERO_CLR) r = OP_ZERO_CLR;
    else if (w[15:11] == OPC_ALWAYS) r = OP_ALWAYS;
    else if (w[15:12] == OPC_BIT_SET) r = OP_BIT_SET;
    return r;
  endfunction

  // Offset field, sign-extended to the widest form
  function automatic logic [OFS_WIDTH-1:0] ofs_field(input logic [INSTR_WIDTH-1:0] w,
                                                     input bbse_op_t op);
    if (op == OP_ALWAYS) return w[OFS_WIDTH-1:0];
    return {{(OFS_WIDTH-8){w[7]}}, w[7:0]};
  endfunction

  // One-hot mask of the selected bit
  function automatic logic [7:0] bit_mask(input logic [INSTR_WIDTH-1:0] w);
    return 8'h01 << w[BIT_IDX_LSB +: 3];
  endfunction

endpackage

`default_nettype wire

// ---- src/bbse_phase_gen.sv ----
// Four-phase sequencer: one core tick per phase.
// Assumes a single clock; reset loads phase one, and the first edge after reset moves to phase two.
`default_nettype none
`timescale 1ns/1ns

module bbse_phase_gen (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  output var  bbse_pkg::bbse_phase_t phase_out
);
  import bbse_pkg::*;

  bbse_phase_t phase_reg;   // Current phase
  bbse_phase_t phase_next;  // Following phase

  ////////////////////////////////////////////////////////////////////////////
  // Next phase, wrapping after the fourth
  always_comb begin
    unique case (phase_reg)
      PH_Q1: phase_next = PH_Q2;
      PH_Q2: phase_next = PH_Q3;
      PH_Q3: phase_next = PH_Q4;
      PH_Q4: phase_next = PH_Q1;
    endcase
  end

  // Register only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_reg <= PH_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase_out = phase_reg;
endmodule

`default_nettype wire

// ---- src/bbse_target_calc.sv ----
// Relative branch target adder.
// Assumes the base is the already-incremented program counter.
`default_nettype none
`timescale 1ns/1ns

module bbse_target_calc #(
  parameter int PC_W = bbse_pkg::PC_WIDTH
) (
  input  wire logic [PC_W-1:0]                pc_next_in,
  input  wire logic [bbse_pkg::OFS_WIDTH-1:0] offset_in,
  output logic      [PC_W-1:0]                target_out
);
  import bbse_pkg::*;

  // Offset doubled must fit the counter
  if (PC_W < OFS_WIDTH + 1) begin : g_chk
    $error("PC_W too narrow for the relative offset");
  end

  logic [PC_W-1:0] step_w;  // Twice the sign-extended offset

  // Base already points past the branch word, so no extra two here
  assign step_w     = {{(PC_W-OFS_WIDTH-1){offset_in[OFS_WIDTH-1]}}, offset_in, 1'b0};
  assign target_out = pc_next_in + step_w;
endmodule

`default_nettype wire

// ---- verification/bbse_testbench.sv ----
// Self-checking bench for the branch and bit-set executor: runs every opcode
// through its phases and compares the program counter and memory ports.
// Assumes bbse_exec and bbse_pkg are compiled first; one clock tick per phase.
`default_nettype none
`timescale 1ns/1ns

// Compare one expected value against what the executor drives
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module testbench;
  import bbse_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic                   clk_in;              // Core clock, one phase a tick
  logic                   arst_n_in;           // Asynchronous reset, active low
  logic [INSTR_WIDTH-1:0] instr_in;            // Word under execution
  logic [PC_WIDTH-1:0]    pc_next_in;          // Incremented counter
  logic                   carry_flag_in;       // Status flags
  logic                   negative_flag_in;
  logic                   overflow_flag_in;
  logic                   zero_flag_in;
  logic [BANK_WIDTH-1:0]  bank_select_reg_in;  // Bank register
  logic                   ext_set_enable_in;   // Extended set on
  logic [DADDR_WIDTH-1:0] index_base_in;       // Index for literal offsets
  logic [7:0]             mem_rdata_in;        // Read data of the file
  bbse_phase_t            phase_out;
  logic                   pc_load_out;
  logic [PC_WIDTH-1:0]    pc_target_out;
  logic                   prefetch_flush_out;
  logic [DADDR_WIDTH-1:0] mem_addr_out;
  logic                   mem_rd_out;
  logic                   mem_wr_out;
  logic [7:0]             mem_wdata_out;
  int                     miscompares;         // Mismatches seen
  int                     check_count;         // Comparisons made
  logic [7:0]             cond_op [4] = '{8'hE3, 8'hE7, 8'hE5, 8'hE1};  // Flag order c n v z
  logic [8:0]             bs_af   [8] = '{9'h1A5, 9'h05F, 9'h060, 9'h05F, 9'h060, 9'h000, 9'h110, 9'h0FF};
  logic                   bs_ext  [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  logic [15:0]            foreign [3] = '{16'hE2FF, 16'h9F00, 16'hD800};  // Not ours

  bbse_exec #(.PC_W(PC_WIDTH)) dut (
    .clk_in             (clk_in),
    .arst_n_in          (arst_n_in),
    .instr_in           (instr_in),
    .pc_next_in         (pc_next_in),
    .carry_flag_in      (carry_flag_in),
    .negative_flag_in   (negative_flag_in),
    .overflow_flag_in   (overflow_flag_in),
    .zero_flag_in       (zero_flag_in),
    .bank_select_reg_in (bank_select_reg_in),
    .ext_set_enable_in  (ext_set_enable_in),
    .index_base_in      (index_base_in),
    .mem_rdata_in       (mem_rdata_in),
    .phase_out          (phase_out),
    .pc_load_out        (pc_load_out),
    .pc_target_out      (pc_target_out),
    .prefetch_flush_out (prefetch_flush_out),
    .mem_addr_out       (mem_addr_out),
    .mem_rd_out         (mem_rd_out),
    .mem_wr_out         (mem_wr_out),
    .mem_wdata_out      (mem_wdata_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Expected values
  // Target from the following word's address; wraps in the counter width
  function automatic logic [PC_WIDTH-1:0] exp_target(input logic [15:0] w, input logic [PC_WIDTH-1:0] pc);
    logic [PC_WIDTH-1:0] ofs;
    if (w[15:11] == 5'h1A) begin
      ofs = {{(PC_WIDTH-11){w[10]}}, w[10:0]};
    end else begin
      ofs = {{(PC_WIDTH-8){w[7]}}, w[7:0]};
    end
    return pc + (ofs << 1);
  endfunction

  // File address for each access mode
  function automatic logic [11:0] exp_addr(input logic [15:0] w, input logic [3:0] bank, input logic ext,
                                           input logic [11:0] idx);
    if (w[8]) return {bank, w[7:0]};
    if (ext && w[7:0] <= 8'h5F) return idx + {4'h0, w[7:0]};
    if (w[7:0] < 8'h60) return {4'h0, w[7:0]};
    return {4'hF, w[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One instruction: entered at the edge that opens its first phase
  task automatic run(input logic [15:0] w, input logic [PC_WIDTH-1:0] pc, input logic [3:0] cnvz,
                     input logic [3:0] bank, input logic ext, input logic [11:0] idx, input logic [7:0] rd);
    logic        taken;
    logic        bset;
    logic [11:0] addr;
    int          last;
    case (w[15:8])
      8'hE3: taken = !cnvz[3];
      8'hE7: taken = !cnvz[2];
      8'hE5: taken = !cnvz[1];
      8'hE1: taken = !cnvz[0];
      default: taken = (w[15:11] == 5'h1A);
    endcase
    bset = (w[15:12] == 4'h8);
    addr = exp_addr(w, bank, ext, idx);
    last = taken ? 7 : 3;
    instr_in <= w;
    pc_next_in <= pc;
    carry_flag_in <= cnvz[3];
    negative_flag_in <= cnvz[2];
    overflow_flag_in <= cnvz[1];
    zero_flag_in <= cnvz[0];
    bank_select_reg_in <= bank;
    ext_set_enable_in <= ext;
    index_base_in <= idx;
    mem_rdata_in <= rd;
    for (int k = 0; k <= last; k++) begin
      @(negedge clk_in);
      `CHK("phase", bbse_phase_t'(k[1:0]), phase_out)
      `CHK("load", taken && k == 3, pc_load_out)
      if (taken && k == 3) `CHK("target", exp_target(w, pc), pc_target_out)
      `CHK("flush", k >= 4, prefetch_flush_out)
      `CHK("read", bset && k == 1, mem_rd_out)
      `CHK("write", bset && k == 3, mem_wr_out)
      if (bset && (k == 1 || k == 3)) `CHK("address", addr, mem_addr_out)
      if (bset && k == 3) `CHK("data", rd | (8'h01 << w[11:9]), mem_wdata_out)
      @(posedge clk_in);
      // A bit-set offered in the idle cycle must be thrown away
      if (taken && k == 3) begin
        instr_in <= 16'h8F00;
      end
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    #(8 * 3000);
    miscompares++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    arst_n_in = 1'b0;
    instr_in = 16'h0000;
    pc_next_in = '0;
    carry_flag_in = 1'b0;
    negative_flag_in = 1'b0;
    overflow_flag_in = 1'b0;
    zero_flag_in = 1'b0;
    bank_select_reg_in = 4'h0;
    ext_set_enable_in = 1'b0;
    index_base_in = 12'h000;
    mem_rdata_in = 8'h00;
    @(negedge clk_in);
    `CHK("reset phase", PH_Q1, phase_out)
    `CHK("reset load", 1'b0, pc_load_out)
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    // Clear-flag branches: other flags set against the tested one, offset limits, wrap both ways
    for (int i = 0; i < 4; i++) begin
      run({cond_op[i], 8'h80}, 21'h000010, ~(4'h8 >> i), 4'h5, 1'b1, 12'h123, 8'h33);
      run({cond_op[i], 8'h7F}, 21'h1FFFFE, 4'h0, 4'hA, 1'b0, 12'h321, 8'hCC);
      run({cond_op[i], 8'h7F}, 21'h000200, 4'h8 >> i, 4'h5, 1'b1, 12'h123, 8'h33);
    end
    // Relative branch ignores every flag
    run(16'hD3FF, 21'h000400, 4'hF, 4'h1, 1'b0, 12'h000, 8'h00);
    run(16'hD400, 21'h000100, 4'hF, 4'h1, 1'b0, 12'h000, 8'h00);
    // Bit set across every index and each addressing mode
    for (int j = 0; j < 8; j++) begin
      run({4'h8, j[2:0], bs_af[j]}, 21'h000300, 4'h0, 4'h3, bs_ext[j], 12'hFF0 - j[11:0],
          j[0] ? ~(8'h01 << j) : 8'h00);
    end
    // Words outside this block leave the load, flush, read and write strobes low
    for (int m = 0; m < 3; m++) begin
      run(foreign[m], 21'h000500, 4'hF, 4'h2, 1'b0, 12'h000, 8'h0F);
    end
    summarize();
  end

endmodule

`undef CHK
`default_nettype wire
